// ===== logic/pcsr_capture.sv
/*
 captures strap line levels once on the first clock after reset release.
 assumes strap lines are stable around reset release and synchronous to the clock.
*/
`timescale 1ns/1ns
module pcsr_capture (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // strap lines
    input wire logic [20:0] strap_line_in,
    // sampled levels
    pcsr_if.capture cap
);
    import pcsr_pkg::*;

    logic done_reg;
    logic [7:0] pll_reg;
    logic [7:0] deskew_reg;
    logic [7:0] clkpin_reg;
    logic [7:0] host_reg;

    // sample once after release, constants under reset
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_reg <= 1'b0;
            pll_reg <= PCSR_RESET_VALUE;
            deskew_reg <= PCSR_RESET_VALUE;
            clkpin_reg <= PCSR_RESET_VALUE;
            host_reg <= PCSR_RESET_VALUE;
        end else if (!done_reg) begin
            done_reg <= 1'b1; // never resampled [R17]
            pll_reg <= {strap_line_in[7:4], strap_line_in[3:2], 2'b00}; // [R1] [R5]
            deskew_reg <= {2'b00, strap_line_in[13:10], 2'b00}; // [R6]
            clkpin_reg <= {3'b000, strap_line_in[20:17], 1'b0}; // [R10]
            host_reg <= {strap_line_in[3:2], 6'h00};
        end
    end

    assign cap.pll_strap = pll_reg;
    assign cap.deskew_strap = deskew_reg;
    assign cap.clkpin_strap = clkpin_reg;
    assign cap.host_mirror = host_reg;
    assign cap.captured = done_reg;
endmodule : pcsr_capture

// ===== logic/pcsr_if.sv
/*
 interface carrying sampled strap levels from the capture module to the register bank.
 assumes a single clock domain.
*/
`timescale 1ns/1ns
interface pcsr_if;
    logic [7:0] pll_strap;
    logic [7:0] deskew_strap;
    logic [7:0] clkpin_strap;
    logic [7:0] host_mirror;
    logic captured;
    modport capture (output pll_strap, deskew_strap, clkpin_strap, host_mirror, captured);
    modport bank (input pll_strap, deskew_strap, clkpin_strap, host_mirror, captured);
endinterface : pcsr_if

// ===== logic/pcsr_pkg.sv
/*
 power-on clock strap register constants: index values, field positions, port addresses, divider codes.
 assumes nothing beyond a SystemVerilog compiler.
*/
package pcsr_pkg;
    // index/data port addresses
    localparam logic [7:0] PCSR_INDEX_PORT = 8'h22;
    localparam logic [7:0] PCSR_DATA_PORT = 8'h23;
    // register indices
    localparam logic [7:0] PCSR_IDX_PLL = 8'h4a;
    localparam logic [7:0] PCSR_IDX_DESKEW = 8'h4b;
    localparam logic [7:0] PCSR_IDX_CLKPIN = 8'h4c;
    localparam logic [7:0] PCSR_IDX_HOST = 8'h5f;
    // field positions
    localparam int PCSR_PLL_RANGE_LSB = 6;
    localparam int PCSR_SYNC_BIT = 5;
    localparam int PCSR_DIV_A_BIT = 4;
    localparam int PCSR_HOSTMIR_LSB = 2;
    localparam int PCSR_DESKEW_LSB = 2;
    localparam int PCSR_DESKEW_BYPASS_BIT = 2;
    localparam int PCSR_DESKEW_USER_BIT = 3;
    localparam int PCSR_DESKEW_START_LSB = 4;
    localparam int PCSR_DOT_BIT = 4;
    localparam int PCSR_MEM_BIT = 3;
    localparam int PCSR_HOST_BIT = 2;
    localparam int PCSR_DIV_B_BIT = 1;
    // writable bits and reserved masks
    localparam logic [7:0] PCSR_PLL_MASK = 8'hfc;
    localparam logic [7:0] PCSR_DESKEW_MASK = 8'h3c;
    localparam logic [7:0] PCSR_CLKPIN_MASK = 8'h1e;
    localparam logic [7:0] PCSR_CLKPIN_WMASK = 8'h10;
    localparam logic [7:0] PCSR_RESET_VALUE = 8'h00;
    localparam logic [7:0] PCSR_DEFAULT_START = 8'h00;
    // pll range codes
    typedef enum logic [1:0] {
        PCSR_RANGE_16_32 = 2'b00,
        PCSR_RANGE_32_64 = 2'b01,
        PCSR_RANGE_ABOVE_64 = 2'b10,
        PCSR_RANGE_RSV = 2'b11
    } pcsr_range_e;
    // divisor codes
    localparam logic [2:0] PCSR_DIV4 = 3'h4;
    localparam logic [2:0] PCSR_DIV3 = 3'h3;
    localparam logic [2:0] PCSR_DIV2 = 3'h2;
endpackage : pcsr_pkg

// ===== logic/pcsr_top.sv
/*
 power-on clock strap register bank: three strap registers behind an index/data io port pair,
 decoded clock-generation controls and clock pin enables.
 assumes an 8-bit io cycle with one-cycle read/write strobes, synchronous to CLK_IN.
*/
// Functional notes
// R1: pll register bits 7:4 hold straps 7:4
// R2: bits 7:6 choose pci pll range
// R3: bit 5 enables memory/host clock sync
// R4: straps 4 and 17 pick pci divisor
// R5: bits 3:2 mirror host register 7:6
// R6: index 4b bits 5:2 hold straps 13:10
// R7: deskew bit 0 enables, 1 bypasses
// R8: user bit selects start from bits 5:4
// R9: strap 13 programs start point msbs
// R10: index 4c bits 4:1 hold straps 20:17
// R11: bit 4 sets dot clock direction
// R12: dot clock bit is software writable
// R13: bit 3 enables memory clock output
// R14: bit 2 sets host clock direction
// R15: bit 1 is second pci divisor strap
// R16: software writes index then data port
// R17: reserved read zero; straps sampled once
`timescale 1ns/1ns
module pcsr_top (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // strap lines
    input wire logic [20:0] STRAP_LINE_IN,
    // io port access
    input wire logic [7:0] IO_ADDR_IN,
    input wire logic [7:0] IO_WDATA_IN,
    input wire logic IO_WR_IN,
    input wire logic IO_RD_IN,
    output logic [7:0] IO_RDATA_OUT,
    output logic IO_RVALID_OUT,
    // clock generation controls
    output pcsr_pkg::pcsr_range_e PCI_PLL_RANGE_OUT,
    output logic MEM_HOST_SYNC_OUT,
    output logic [2:0] PCI_BUS_CLOCK_DIV_OUT,
    output logic DESKEW_ENABLE_OUT,
    output logic DESKEW_USER_START_OUT,
    output logic [1:0] DESKEW_START_OUT,
    // clock pin enables
    output logic DOT_CLOCK_OE_OUT,
    output logic MEMORY_CLOCK_OUT_PIN_OE_OUT,
    output logic HOST_CLOCK_OE_OUT
);
    import pcsr_pkg::*;

    pcsr_if straps ();

    logic [7:0] index_reg;
    logic dot_reg;
    logic dot_loaded_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [7:0] pll_strap_reg;
    logic [7:0] deskew_strap_reg;
    logic [7:0] clock_pin_strap_reg;
    logic [7:0] rdata_next;

    // divisor decode from the two divisor straps
    function automatic logic [2:0] pcsr_divisor(input logic div_a, input logic div_b);
        logic [2:0] d;
        d = PCSR_DIV4;
        if (div_a && div_b) begin
            d = PCSR_DIV2;
        end else if (div_a) begin
            d = PCSR_DIV3;
        end
        return d;
    endfunction : pcsr_divisor

    pcsr_capture u_capture (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .strap_line_in(STRAP_LINE_IN),
        .cap(straps)
    );

    // index port write selects register
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            index_reg <= PCSR_RESET_VALUE;
        end else if (IO_WR_IN && IO_ADDR_IN == PCSR_INDEX_PORT) begin
            index_reg <= IO_WDATA_IN; // [R16]
        end
    end

    // dot clock bit: strap value then software writes
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            dot_reg <= 1'b0;
            dot_loaded_reg <= 1'b0;
        end else if (straps.captured && !dot_loaded_reg) begin
            dot_loaded_reg <= 1'b1;
            dot_reg <= straps.clkpin_strap[PCSR_DOT_BIT];
        end else if (IO_WR_IN && IO_ADDR_IN == PCSR_DATA_PORT && index_reg == PCSR_IDX_CLKPIN) begin
            dot_reg <= IO_WDATA_IN[PCSR_DOT_BIT]; // [R12] other bits ignore writes [R17]
        end
    end

    // register images with reserved bits forced low
    always_comb begin
        pll_strap_reg = straps.pll_strap & PCSR_PLL_MASK; // [R1] [R17]
        pll_strap_reg[PCSR_HOSTMIR_LSB +: 2] = straps.host_mirror[7:6]; // [R5]
        deskew_strap_reg = straps.deskew_strap & PCSR_DESKEW_MASK; // [R6] [R17]
        clock_pin_strap_reg = straps.clkpin_strap & PCSR_CLKPIN_MASK & ~PCSR_CLKPIN_WMASK; // [R10]
        clock_pin_strap_reg[PCSR_DOT_BIT] = dot_reg; // [R12]
    end

    // data port read mux, unmapped index reads zero
    always_comb begin
        rdata_next = PCSR_RESET_VALUE;
        if (IO_ADDR_IN == PCSR_INDEX_PORT) begin
            rdata_next = index_reg;
        end else begin
            case (index_reg)
                PCSR_IDX_PLL: rdata_next = pll_strap_reg;
                PCSR_IDX_DESKEW: rdata_next = deskew_strap_reg;
                PCSR_IDX_CLKPIN: rdata_next = clock_pin_strap_reg;
                default: rdata_next = PCSR_RESET_VALUE; // [R17]
            endcase
        end
    end

    // registered read answer one cycle after the strobe
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rdata_reg <= PCSR_RESET_VALUE;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= IO_RD_IN && (IO_ADDR_IN == PCSR_INDEX_PORT || IO_ADDR_IN == PCSR_DATA_PORT);
            if (IO_RD_IN && (IO_ADDR_IN == PCSR_INDEX_PORT || IO_ADDR_IN == PCSR_DATA_PORT)) begin
                rdata_reg <= rdata_next; // [R16]
            end
        end
    end

    assign IO_RDATA_OUT = rdata_reg;
    assign IO_RVALID_OUT = rvalid_reg;

    // clock generation controls
    assign PCI_PLL_RANGE_OUT = pcsr_range_e'(pll_strap_reg[PCSR_PLL_RANGE_LSB +: 2]); // [R2]
    assign MEM_HOST_SYNC_OUT = pll_strap_reg[PCSR_SYNC_BIT]; // [R3]
    assign PCI_BUS_CLOCK_DIV_OUT = pcsr_divisor(pll_strap_reg[PCSR_DIV_A_BIT],
        clock_pin_strap_reg[PCSR_DIV_B_BIT]); // [R4] [R15]
    assign DESKEW_ENABLE_OUT = !deskew_strap_reg[PCSR_DESKEW_BYPASS_BIT]; // [R7]
    assign DESKEW_USER_START_OUT = deskew_strap_reg[PCSR_DESKEW_USER_BIT]; // [R8]
    // user start from bits 5:4, else default; bit 5 (strap 13) sets the start msb
    assign DESKEW_START_OUT = deskew_strap_reg[PCSR_DESKEW_USER_BIT]
        ? deskew_strap_reg[PCSR_DESKEW_START_LSB +: 2] : PCSR_DEFAULT_START[1:0]; // [R8] [R9]

    // clock pin direction enables
    assign DOT_CLOCK_OE_OUT = clock_pin_strap_reg[PCSR_DOT_BIT]; // [R11]
    assign MEMORY_CLOCK_OUT_PIN_OE_OUT = clock_pin_strap_reg[PCSR_MEM_BIT]; // [R13]
    assign HOST_CLOCK_OE_OUT = clock_pin_strap_reg[PCSR_HOST_BIT]; // [R14]
endmodule : pcsr_top

// ===== tb/pcsr_assertions.sv
/*
 checker for the strap register bank top ports.
 assumes straps hold still from reset release until the first edge.
*/
`timescale 1ns/1ns
module pcsr_chk (
    // clock, reset and inputs
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [20:0] STRAP_LINE_IN,
    input wire logic [7:0] IO_ADDR_IN,
    input wire logic IO_RD_IN,
    // outputs watched
    input wire logic IO_RVALID_OUT,
    input wire pcsr_pkg::pcsr_range_e PCI_PLL_RANGE_OUT,
    input wire logic MEM_HOST_SYNC_OUT,
    input wire logic [2:0] PCI_BUS_CLOCK_DIV_OUT,
    input wire logic DESKEW_ENABLE_OUT,
    input wire logic DESKEW_USER_START_OUT,
    input wire logic [1:0] DESKEW_START_OUT,
    input wire logic MEMORY_CLOCK_OUT_PIN_OE_OUT,
    input wire logic HOST_CLOCK_OE_OUT
);
    import pcsr_pkg::*;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    logic [1:0] age_reg;
    logic [20:0] snap_reg;
    logic ok;
    logic rd_hit;
    // own copy of the straps, taken at the first edge after release
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
    always_ff @(posedge CLK_IN) snap_reg <= (age_reg == 2'h0) ? STRAP_LINE_IN : snap_reg;
    assign ok = age_reg != 2'h0;
    assign rd_hit = IO_RD_IN && (IO_ADDR_IN == PCSR_INDEX_PORT || IO_ADDR_IN == PCSR_DATA_PORT);
    rvalid_answer_a: assert property (rd_hit |=> IO_RVALID_OUT) else $error("read not answered");
    stray_valid_a: assert property (!rd_hit |=> !IO_RVALID_OUT) else $error("answer without read");
    pll_range_a: assert property (ok |-> PCI_PLL_RANGE_OUT == snap_reg[7:6]) else $error("pll range");
    sync_bit_a: assert property (ok |-> MEM_HOST_SYNC_OUT == snap_reg[5]) else $error("sync bit");
    pci_divisor_a: assert property (ok |-> PCI_BUS_CLOCK_DIV_OUT == (!snap_reg[4] ? PCSR_DIV4 :
        snap_reg[17] ? PCSR_DIV2 : PCSR_DIV3)) else $error("pci divisor");
    deskew_mode_a: assert property (ok |-> DESKEW_ENABLE_OUT == !snap_reg[10] &&
        DESKEW_USER_START_OUT == snap_reg[11]) else $error("deskew mode");
    deskew_start_a: assert property (ok |-> DESKEW_START_OUT == (snap_reg[11] ? snap_reg[13:12] : 2'b00))
        else $error("deskew start");
    clock_pins_a: assert property (ok |-> MEMORY_CLOCK_OUT_PIN_OE_OUT == snap_reg[19] &&
        HOST_CLOCK_OE_OUT == snap_reg[18]) else $error("clock pins");
    sampled_once_a: assert property (ok |=> $stable({MEMORY_CLOCK_OUT_PIN_OE_OUT, PCI_PLL_RANGE_OUT}))
        else $error("straps resampled");
    cover property (IO_RVALID_OUT);
    cover property (ok && DESKEW_USER_START_OUT);
    cover property (ok && PCI_BUS_CLOCK_DIV_OUT == PCSR_DIV3);
endmodule : pcsr_chk
bind pcsr_top pcsr_chk u_chk (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .STRAP_LINE_IN(STRAP_LINE_IN),
    .IO_ADDR_IN(IO_ADDR_IN), .IO_RD_IN(IO_RD_IN), .IO_RVALID_OUT(IO_RVALID_OUT),
    .PCI_PLL_RANGE_OUT(PCI_PLL_RANGE_OUT), .MEM_HOST_SYNC_OUT(MEM_HOST_SYNC_OUT),
    .PCI_BUS_CLOCK_DIV_OUT(PCI_BUS_CLOCK_DIV_OUT), .DESKEW_ENABLE_OUT(DESKEW_ENABLE_OUT),
    .DESKEW_USER_START_OUT(DESKEW_USER_START_OUT), .DESKEW_START_OUT(DESKEW_START_OUT),
    .MEMORY_CLOCK_OUT_PIN_OE_OUT(MEMORY_CLOCK_OUT_PIN_OE_OUT), .HOST_CLOCK_OE_OUT(HOST_CLOCK_OE_OUT));

// ===== tb/pcsr_board.sv
/*
 board strap resistors feeding the strap lines.
 assumes the bench picks user-set levels through cfg_in.
*/
`timescale 1ns/1ns
module pcsr_board (
    // clock and user levels
    input wire logic clk_in,
    input wire logic [20:0] cfg_in,
    // strap lines
    output logic [20:0] strap_line_out
);
    logic wobble_reg = 1'b0;
    // open lines 8, 9 and 15 float, so they change every cycle
    always @(posedge clk_in) wobble_reg <= ~wobble_reg;
    // lines 14 and 16 carry fixed pull-ups
    assign strap_line_out = (cfg_in & ~21'h008300) | 21'h014000 | ({21{wobble_reg}} & 21'h008300);
endmodule : pcsr_board

// ===== tb/tb_top.sv
/*
 self-checking bench for the strap register bank.
 assumes the board model supplies the strap levels.
*/
`timescale 1ns/1ns
module tb_top;
    import pcsr_pkg::*;
    logic clk, arst_n, wr, rd, rvalid, dot_oe, dot_e;
    logic [7:0] addr, wdata, rdata, wd;
    logic [20:0] cfg, strap, s;
    logic [7:0] idx_tab [5] = '{PCSR_IDX_PLL, PCSR_IDX_DESKEW, PCSR_IDX_CLKPIN, PCSR_IDX_HOST, 8'h00};
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    pcsr_board u_board (.clk_in(clk), .cfg_in(cfg), .strap_line_out(strap));
    pcsr_top DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .STRAP_LINE_IN(strap), .IO_ADDR_IN(addr),
        .IO_WDATA_IN(wdata), .IO_WR_IN(wr), .IO_RD_IN(rd), .IO_RDATA_OUT(rdata), .IO_RVALID_OUT(rvalid),
        .PCI_PLL_RANGE_OUT(), .MEM_HOST_SYNC_OUT(), .PCI_BUS_CLOCK_DIV_OUT(), .DESKEW_ENABLE_OUT(),
        .DESKEW_USER_START_OUT(), .DESKEW_START_OUT(), .DOT_CLOCK_OE_OUT(dot_oe),
        .MEMORY_CLOCK_OUT_PIN_OE_OUT(), .HOST_CLOCK_OE_OUT());
    // expected register contents from the latched straps
    function automatic logic [7:0] exp_reg(input logic [7:0] idx, input logic [20:0] v, input logic d);
        case (idx)
            PCSR_IDX_PLL: return {v[7:4], v[3:2], 2'b00};
            PCSR_IDX_DESKEW: return {2'b00, v[13:10], 2'b00};
            PCSR_IDX_CLKPIN: return {3'b000, d, v[19:17], 1'b0};
            default: return 8'h00;
        endcase
    endfunction : exp_reg
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one io cycle; a read checks the answer in the cycle after the taking edge, while it stands
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        if (!w) begin
            chk({7'h00, rvalid}, {7'h00, a == PCSR_INDEX_PORT || a == PCSR_DATA_PORT});
            if (rvalid === 1'b1) chk(rdata, d);
        end
    endtask : io
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            close_out();
        end
    end
    // main sequence: corner straps first, then random ones
    initial begin
        {arst_n, wr, rd, addr, wdata, cfg, dot_e} = '0;
        void'($urandom(32'hb0b444e9));
        for (int t = 0; t < 6; t++) begin
            arst_n = 1'b0;
            cfg = (t == 0) ? 21'h000000 : (t == 1) ? 21'h1fffff : 21'($urandom);
            repeat (12) @(negedge clk);
            arst_n = 1'b1;
            s = strap;
            repeat (3) @(negedge clk);
            cfg = ~cfg;
            dot_e = s[20];
            chk({7'h00, dot_oe}, {7'h00, dot_e});
            foreach (idx_tab[k]) begin
                wd = 8'($urandom);
                io(1'b1, PCSR_INDEX_PORT, idx_tab[k]);
                io(1'b0, PCSR_INDEX_PORT, idx_tab[k]);
                io(1'b1, PCSR_DATA_PORT, wd);
                if (idx_tab[k] == PCSR_IDX_CLKPIN) dot_e = wd[4];
                io(1'b1, 8'h24, 8'hff);
                io(1'b0, 8'h24, 8'h00);
                io(1'b0, PCSR_DATA_PORT, exp_reg(idx_tab[k], s, dot_e));
                chk({7'h00, dot_oe}, {7'h00, dot_e});
            end
            $display("test %0d done", t);
        end
        close_out();
    end
endmodule : tb_top
